// ==== logic/bsp_ports.sv ====
// ports zero, one and two with external bus sharing and strap capture
// assumes the bus controller issues one access at a time on xreq,
// and the cpu reaches the registers over the sfr port below
`timescale 1ns/1ps
`default_nettype none
// How it works
// - port 0 halves written independently
// - port 1 halves written independently
// - half data registers hold bits 7-0
// - direction 0 input high-z, 1 output
// - port 2 per-line direction and open-drain
// - port 2 data resets to zero
// - external bus uses port 0 for data
// - byte demux bus leaves port 0 high free
// - port 0 pulled-up input during reset
// - reset loads bus config and strap byte each cycle
// - pull-ups off, chosen mode after reset
// - mux access: address, then high-z read
// - byte bus splits words low then high
// - writes drive data; demux only data
// - bus controller owns direction and latch
// - last software direction returns after bus
// - demux bus drives address on port 1
// - mux-only bus leaves port 1 free
// - port 1 top lines sampled every eight
// - capture stays active in address mode
module bsp_ports (
  input wire logic clk,
  input wire logic srst,
  input wire bsp_pkg::bsp_sfr_t sfr,
  output logic [15:0] sfr_rdata,
  input wire bsp_pkg::bsp_xreq_t xreq,
  output logic xready,
  output logic xack,
  output logic [15:0] xrdata,
  output logic ext_bus_en,
  input wire logic [15:0] p0_in,
  output logic [15:0] p0_out,
  output logic [15:0] p0_oe,
  output logic p0_pullup,
  input wire logic [15:0] p1_in,
  output logic [15:0] p1_out,
  output logic [15:0] p1_oe,
  input wire logic [15:0] p2_in,
  output logic [15:0] p2_out,
  output logic [15:0] p2_oe,
  output logic [3:0] cc2_capture
);
  import bsp_pkg::*;

  logic [15:0] p0_s, p1_s, p2_s;
  logic [7:0] p0l_data, p0h_data, p1l_data, p1h_data;
  logic [7:0] p0l_dir, p0h_dir, p1l_dir, p1h_dir;
  logic [15:0] p2_data, p2_dir, p2_drain;
  logic [15:0] bus_cfg;
  logic [7:0] rcfg;
  bsp_state_t state;
  logic [1:0] wait_cnt;
  logic byte_idx;
  bsp_xreq_t cur;
  logic [2:0] cap_div;
  logic [1:0] mode;
  logic own_p0h, own_p1, is_mux, is_8, bus_drv;
  logic [15:0] bus_val, lane_wdata;
  logic [15:0] next_p0_oe, next_p1_oe, next_p2_oe;

  bsp_sync #(.W(16)) u_s0 (.clk(clk), .d(p0_in), .q(p0_s));
  bsp_sync #(.W(16)) u_s1 (.clk(clk), .d(p1_in), .q(p1_s));
  bsp_sync #(.W(16)) u_s2 (.clk(clk), .d(p2_in), .q(p2_s));

  function automatic logic hit(input bsp_sfr_t r, input logic [15:0] a,
                               input logic sp);
    hit = (r.addr == a) && (r.ext == sp);
  endfunction : hit

  // an input line reads the pin, an output line its latch
  function automatic logic [15:0] half(input logic [7:0] lat,
                                       input logic [7:0] dir,
                                       input logic [7:0] pin);
    half = {8'h00, (dir & lat) | (~dir & pin)};
  endfunction : half

  function automatic logic wr(input bsp_sfr_t r, input logic [15:0] a,
                              input logic sp);
    wr = r.wr && hit(r, a, sp);
  endfunction : wr

  assign mode = bus_cfg[CFG_MODE_LSB +: 2];
  assign is_mux = mode[0];
  assign is_8 = (mode == MODE_DEMUX8) || (mode == MODE_MUX8);
  // byte demux bus leaves the high half to software
  assign own_p0h = ext_bus_en && (mode != MODE_DEMUX8);
  assign own_p1 = ext_bus_en && !is_mux;
  assign lane_wdata = is_8 ? {8'h00, byte_idx ? cur.wdata[15:8]
                                                : cur.wdata[7:0]}
                           : cur.wdata;

  always_comb begin
    bus_drv = 1'b0;
    bus_val = {p0h_data, p0l_data};
    case (state)
      ST_ADDR: begin
        bus_drv = 1'b1;
        bus_val = cur.addr;
      end
      ST_DATA: begin
        bus_drv = cur.write;
        bus_val = lane_wdata;
      end
      default: begin
        bus_drv = 1'b0;
      end
    endcase
  end

  // strap capture and configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_cfg <= {8'h00, p0_s[7:0]};
      rcfg <= p0_s[15:8];
      ext_bus_en <= 1'b0;
      p0_pullup <= 1'b1;
    end else begin
      p0_pullup <= 1'b0;
      ext_bus_en <= bus_cfg[CFG_EN_BIT];
      if (wr(sfr, ADDR_BUSCFG, SP_STD)) begin
        bus_cfg <= sfr.wdata;
      end
    end
  end

  // port 0 latches; the bus controller loads them while it owns the pins
  always_ff @(posedge clk) begin
    if (srst) begin
      p0l_data <= HALF_RESET;
      p0h_data <= HALF_RESET;
    end else if (ext_bus_en && bus_drv) begin
      p0l_data <= bus_val[7:0];
      if (own_p0h) begin
        p0h_data <= bus_val[15:8];
      end else if (wr(sfr, ADDR_P0H, SP_STD)) begin
        p0h_data <= sfr.wdata[7:0];
      end
    end else begin
      if (wr(sfr, ADDR_P0L, SP_STD)) begin
        p0l_data <= sfr.wdata[7:0];
      end
      if (wr(sfr, ADDR_P0H, SP_STD)) begin
        p0h_data <= sfr.wdata[7:0];
      end
    end
  end

  // port 1 latches carry the address in demultiplexed modes
  always_ff @(posedge clk) begin
    if (srst) begin
      p1l_data <= HALF_RESET;
      p1h_data <= HALF_RESET;
    end else if (own_p1) begin
      {p1h_data, p1l_data} <= cur.addr;
    end else begin
      if (wr(sfr, ADDR_PORT1_LO, SP_STD)) begin
        p1l_data <= sfr.wdata[7:0];
      end
      if (wr(sfr, ADDR_PORT1_HI, SP_STD)) begin
        p1h_data <= sfr.wdata[7:0];
      end
    end
  end

  // direction registers keep software values through bus mode
  always_ff @(posedge clk) begin
    if (srst) begin
      p0l_dir <= HALF_RESET;
      p0h_dir <= HALF_RESET;
      p1l_dir <= HALF_RESET;
      p1h_dir <= HALF_RESET;
    end else begin
      if (wr(sfr, ADDR_DP0L, SP_EXT)) p0l_dir <= sfr.wdata[7:0];
      if (wr(sfr, ADDR_DP0H, SP_EXT)) p0h_dir <= sfr.wdata[7:0];
      if (wr(sfr, ADDR_PORT1_LO_DIR, SP_EXT)) p1l_dir <= sfr.wdata[7:0];
      if (wr(sfr, ADDR_PORT1_HI_DIR, SP_EXT)) p1h_dir <= sfr.wdata[7:0];
    end
  end

  // port 2 registers
  always_ff @(posedge clk) begin
    if (srst) begin
      p2_data <= PORT2_RESET;
      p2_dir <= PORT2_DIR_RESET;
      p2_drain <= PORT2_DRAIN_RESET;
    end else begin
      if (wr(sfr, ADDR_PORT2, SP_STD)) p2_data <= sfr.wdata;
      if (wr(sfr, ADDR_PORT2_DIR, SP_STD)) p2_dir <= sfr.wdata;
      if (wr(sfr, ADDR_PORT2_DRAIN, SP_EXT)) p2_drain <= sfr.wdata;
    end
  end

  // pin drive: bus ownership overrides the direction registers
  always_comb begin
    next_p0_oe = {p0h_dir, p0l_dir};
    if (ext_bus_en) begin
      next_p0_oe[7:0] = {8{bus_drv}};
      if (own_p0h) next_p0_oe[15:8] = {8{bus_drv && !is_8}};
    end
    if (p0_pullup) next_p0_oe = 16'h0000;
    next_p1_oe = own_p1 ? 16'hffff : {p1h_dir, p1l_dir};
    // open drain lines release the pin instead of driving high
    next_p2_oe = p2_dir & ~(p2_drain & p2_data);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      p0_oe <= 16'h0000;
      p1_oe <= 16'h0000;
      p2_oe <= 16'h0000;
      p0_out <= 16'h0000;
      p1_out <= 16'h0000;
      p2_out <= 16'h0000;
    end else begin
      p0_oe <= next_p0_oe;
      p1_oe <= next_p1_oe;
      p2_oe <= next_p2_oe;
      // bus values go out with their enable, not one cycle behind it
      if (ext_bus_en && bus_drv) begin
        p0_out <= own_p0h ? bus_val : {p0h_data, bus_val[7:0]};
      end else begin
        p0_out <= {p0h_data, p0l_data};
      end
      p1_out <= own_p1 ? cur.addr : {p1h_data, p1l_data};
      p2_out <= p2_data & ~p2_drain;
    end
  end

  // register reads answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= 16'h0000;
    end else if (sfr.rd) begin
      if (hit(sfr, ADDR_P0L, SP_STD))
        sfr_rdata <= half(p0l_data, p0l_dir, p0_s[7:0]);
      else if (hit(sfr, ADDR_P0H, SP_STD))
        sfr_rdata <= half(p0h_data, p0h_dir, p0_s[15:8]);
      else if (hit(sfr, ADDR_PORT1_LO, SP_STD))
        sfr_rdata <= half(p1l_data, p1l_dir, p1_s[7:0]);
      else if (hit(sfr, ADDR_PORT1_HI, SP_STD))
        sfr_rdata <= half(p1h_data, p1h_dir, p1_s[15:8]);
      else if (hit(sfr, ADDR_DP0L, SP_EXT)) sfr_rdata <= {8'h00, p0l_dir};
      else if (hit(sfr, ADDR_DP0H, SP_EXT)) sfr_rdata <= {8'h00, p0h_dir};
      else if (hit(sfr, ADDR_PORT1_LO_DIR, SP_EXT))
        sfr_rdata <= {8'h00, p1l_dir};
      else if (hit(sfr, ADDR_PORT1_HI_DIR, SP_EXT))
        sfr_rdata <= {8'h00, p1h_dir};
      else if (hit(sfr, ADDR_PORT2, SP_STD))
        sfr_rdata <= (p2_dir & p2_data) | (~p2_dir & p2_s);
      else if (hit(sfr, ADDR_PORT2_DIR, SP_STD)) sfr_rdata <= p2_dir;
      else if (hit(sfr, ADDR_PORT2_DRAIN, SP_EXT)) sfr_rdata <= p2_drain;
      else if (hit(sfr, ADDR_BUSCFG, SP_STD)) sfr_rdata <= bus_cfg;
      else if (hit(sfr, ADDR_RCFG, SP_EXT)) sfr_rdata <= {8'h00, rcfg};
      else sfr_rdata <= 16'h0000;
    end else begin
      sfr_rdata <= 16'h0000;
    end
  end

  // external access sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      wait_cnt <= 2'd0;
      byte_idx <= 1'b0;
      cur <= '0;
      xready <= 1'b0;
      xack <= 1'b0;
      xrdata <= 16'h0000;
    end else begin
      xack <= 1'b0;
      case (state)
        ST_IDLE: begin
          xready <= ext_bus_en;
          if (xreq.valid && xready) begin
            cur <= xreq;
            byte_idx <= 1'b0;
            wait_cnt <= 2'd0;
            xready <= 1'b0;
            state <= is_mux ? ST_ADDR : ST_DATA;
          end
        end
        ST_ADDR: begin
          state <= ST_DATA;
        end
        ST_DATA: begin
          if (wait_cnt == DATA_WAIT) begin
            if (!cur.write) begin
              if (!is_8) xrdata <= p0_s;
              else if (byte_idx) xrdata[15:8] <= p0_s[7:0];
              else xrdata <= {8'h00, p0_s[7:0]};
            end
            if (is_8 && cur.word && !byte_idx) begin
              byte_idx <= 1'b1;
              cur.addr <= cur.addr + 16'h0001;
              wait_cnt <= 2'd0;
              state <= is_mux ? ST_ADDR : ST_DATA;
            end else begin
              xack <= 1'b1;
              state <= ST_IDLE;
            end
          end else begin
            wait_cnt <= wait_cnt + 2'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // capture lines see the pins, so address changes still capture
  always_ff @(posedge clk) begin
    if (srst) begin
      cap_div <= 3'd0;
      cc2_capture <= 4'h0;
    end else begin
      cap_div <= cap_div + 3'd1;
      if (cap_div == CAP_LAST) cc2_capture <= p1_s[15:12];
    end
  end

  property p_p0_split;
    @(posedge clk) disable iff (srst)
      (wr(sfr, ADDR_P0L, SP_STD) && !ext_bus_en) |=> $stable(p0h_data);
  endproperty
  a_p0_split: assert property (p_p0_split) else $error("p0 high changed");

  property p_p1_split;
    @(posedge clk) disable iff (srst)
      (wr(sfr, ADDR_PORT1_HI, SP_STD) && !own_p1) |=> $stable(p1l_data);
  endproperty
  a_p1_split: assert property (p_p1_split) else $error("p1 low changed");

  property p_resv;
    @(posedge clk) disable iff (srst)
      (sfr.rd && hit(sfr, ADDR_P0L, SP_STD)) |=> sfr_rdata[15:8] == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");

  property p_dir;
    @(posedge clk) disable iff (srst)
      !own_p1 |=> p1_oe == $past({p1h_dir, p1l_dir});
  endproperty
  a_dir: assert property (p_dir) else $error("p1 oe not direction");

  property p_drain;
    @(posedge clk) disable iff (srst)
      1'b1 |=> (p2_oe & $past(p2_drain & p2_data)) == 16'h0000;
  endproperty
  a_drain: assert property (p_drain) else $error("drain drives high");

  property p_p2_rst;
    @(posedge clk) srst |=> p2_data == PORT2_RESET && p2_out == 16'h0000;
  endproperty
  a_p2_rst: assert property (p_p2_rst) else $error("p2 reset value");

  property p_strap;
    // the strap pins need reset held long enough to clear the sync
    @(posedge clk) srst && $past(srst, 3) |=> p0_pullup && p0_oe == 16'h0000
                            && rcfg == $past(p0_s[15:8]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap phase wrong");

  property p_pull_off;
    @(posedge clk) disable iff (srst) !srst |=> !p0_pullup;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull-up on");

  property p_mux_addr;
    @(posedge clk) disable iff (srst)
      state == ST_ADDR |=> p0_out[7:0] == $past(cur.addr[7:0])
                           && p0_oe[7:0] == 8'hff;
  endproperty
  a_mux_addr: assert property (p_mux_addr) else $error("no address out");

  property p_read_hiz;
    @(posedge clk) disable iff (srst)
      (state == ST_DATA && !cur.write) |=> p0_oe[7:0] == 8'h00;
  endproperty
  a_read_hiz: assert property (p_read_hiz) else $error("read drives");

  property p_cap;
    @(posedge clk) disable iff (srst)
      cap_div != CAP_LAST |=> $stable(cc2_capture);
  endproperty
  a_cap: assert property (p_cap) else $error("capture off period");

  c_mux_read: cover property (@(posedge clk) disable iff (srst)
    xack && is_mux && !cur.write);
  c_demux_write: cover property (@(posedge clk) disable iff (srst)
    xack && !is_mux && cur.write);
  c_byte_word: cover property (@(posedge clk) disable iff (srst)
    xack && is_8 && cur.word);
endmodule : bsp_ports
`default_nettype wire

// ==== logic/bsp_pkg.sv ====
// constants, types and register map of the bus-shared parallel ports
// assumes one system clock; the caller includes nothing else
package bsp_pkg;
  // register map: address and space flag (0 standard, 1 extended)
  localparam logic [15:0] ADDR_P0L = 16'hff00;
  localparam logic [15:0] ADDR_P0H = 16'hff02;
  localparam logic [15:0] ADDR_PORT1_LO = 16'hff04;
  localparam logic [15:0] ADDR_PORT1_HI = 16'hff06;
  localparam logic [15:0] ADDR_BUSCFG = 16'hff0c;
  localparam logic [15:0] ADDR_PORT2 = 16'hffc0;
  localparam logic [15:0] ADDR_PORT2_DIR = 16'hffc2;
  localparam logic [15:0] ADDR_DP0L = 16'hf100;
  localparam logic [15:0] ADDR_DP0H = 16'hf102;
  localparam logic [15:0] ADDR_PORT1_LO_DIR = 16'hf104;
  localparam logic [15:0] ADDR_PORT1_HI_DIR = 16'hf106;
  localparam logic [15:0] ADDR_RCFG = 16'hf108;
  localparam logic [15:0] ADDR_PORT2_DRAIN = 16'hf1c2;
  localparam logic SP_STD = 1'b0;
  localparam logic SP_EXT = 1'b1;
  // reset values
  localparam logic [15:0] PORT2_RESET = 16'h0000;
  localparam logic [15:0] PORT2_DIR_RESET = 16'h0000;
  localparam logic [15:0] PORT2_DRAIN_RESET = 16'h0000;
  localparam logic [7:0] HALF_RESET = 8'h00;
  // bus configuration fields, loaded from the low port 0 straps
  localparam int CFG_MODE_LSB = 6;
  localparam int CFG_EN_BIT = 5;
  localparam logic [1:0] MODE_DEMUX8 = 2'b00;
  localparam logic [1:0] MODE_MUX8 = 2'b01;
  localparam logic [1:0] MODE_DEMUX16 = 2'b10;
  localparam logic [1:0] MODE_MUX16 = 2'b11;
  // last count of a four-cycle data phase; pins settle, then two sync
  // stages, before the sample
  localparam logic [1:0] DATA_WAIT = 2'd3;
  // last count of the eight-clock capture sampling period
  localparam logic [2:0] CAP_LAST = 3'd7;
  typedef enum {ST_IDLE, ST_ADDR, ST_DATA} bsp_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic ext;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bsp_sfr_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bsp_xreq_t;
endpackage : bsp_pkg

// ==== logic/bsp_sync.sv ====
// two-stage synchroniser for asynchronous pin levels
// assumes nothing beyond the system clock
`timescale 1ns/1ps
`default_nettype none
module bsp_sync #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  initial begin
    if (W < 1) $error("width must be positive");
  end
  // no reset: straps must pass through while reset is held
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule : bsp_sync
`default_nettype wire

// ==== verif/bsp_mem_model.sv ====
// behavioural external memory on the shared ports zero and one
// assumes the bench merges mem_d onto lines the ports leave undriven
`timescale 1ns/1ps
`default_nettype none
module bsp_mem_model (
  input wire logic clk,
  input wire logic demux,
  input wire logic [15:0] p0_out,
  input wire logic [15:0] p0_oe,
  input wire logic [15:0] p1_out,
  output logic [15:0] mem_d,
  output logic [15:0] seen
);
  logic [15:0] addr;
  logic [15:0] addr_hi;
  // no strobe reaches us, so the last fully driven value stands in
  // for the address latch; in a write it ends up holding the data
  always_ff @(posedge clk) begin
    if (p0_oe[7:0] == 8'hff) begin
      seen <= p0_out;
    end
  end
  // always selected: drives whenever the port lets go of the lines
  assign addr = demux ? p1_out : seen;
  assign addr_hi = addr + 16'h0001;
  assign mem_d = {addr_hi[7:0] ^ 8'h96, addr[7:0] ^ 8'h96};
endmodule : bsp_mem_model
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the bus-shared parallel ports
// assumes bsp_pkg and bsp_ports compiled first; straps 16'h3c1f
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bsp_pkg::*;
  logic clk, srst, xready, xack, ext_bus_en, p0_pullup, mem_on;
  bsp_sfr_t sfr;
  bsp_xreq_t xreq;
  logic [15:0] sfr_rdata, xrdata, p0_in, p0_out, p0_oe, p1_in, p1_out;
  logic [15:0] p1_oe, p2_in, p2_out, p2_oe, tb_p0, tb_p1, tb_p2;
  logic [15:0] mem_d, seen, r, a, a1, w;
  logic [15:0] rv [4];
  logic [15:0] da [4] = '{ADDR_P0L, ADDR_P0H, ADDR_PORT1_LO,
                          ADDR_PORT1_HI};
  logic [15:0] dd [4] = '{ADDR_DP0L, ADDR_DP0H, ADDR_PORT1_LO_DIR,
                          ADDR_PORT1_HI_DIR};
  logic [3:0] cc2_capture;
  logic [1:0] m;
  logic rd_d;
  logic [15:0] q [$];
  logic [16:0] xq [$];
  logic [16:0] e;
  int error_cnt, compares, cyc, seed;
  bsp_ports bsp_ports_i (.clk(clk), .srst(srst), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .xreq(xreq), .xready(xready), .xack(xack),
    .xrdata(xrdata), .ext_bus_en(ext_bus_en), .p0_in(p0_in),
    .p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pullup),
    .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p2_in(p2_in),
    .p2_out(p2_out), .p2_oe(p2_oe), .cc2_capture(cc2_capture));
  bsp_mem_model bsp_mem_model_i (.clk(clk), .demux(~m[0]),
    .p0_out(p0_out), .p0_oe(p0_oe), .p1_out(p1_out), .mem_d(mem_d),
    .seen(seen));
  assign p0_in = (p0_oe & p0_out) | (~p0_oe & (mem_on ? mem_d : tb_p0));
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & tb_p1);
  assign p2_in = (p2_oe & p2_out) | (~p2_oe & tb_p2);
  always #20 clk = ~clk;
  task automatic test_done();
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic x, input logic [15:0] ad, input logic [15:0] d);
    @(posedge clk);
    sfr <= '{wr:1'b1, rd:1'b0, ext:x, addr:ad, wdata:d};
    @(posedge clk);
    sfr <= '0;
  endtask : wr
  task automatic rd(input logic x, input logic [15:0] ad, input logic [15:0] v);
    @(posedge clk);
    sfr <= '{wr:1'b0, rd:1'b1, ext:x, addr:ad, wdata:16'h0000};
    q.push_back(v);
    @(posedge clk);
    sfr <= '0;
  endtask : rd
  task automatic xacc(input logic wi, input logic [15:0] ad, input logic [15:0] d,
                      input logic [15:0] v, input logic [15:0] lat);
    int n;
    n = 0;
    @(posedge clk);
    xreq <= '{valid:1'b1, write:wi, word:1'b1, addr:ad, wdata:d};
    xq.push_back({~wi, v});
    do begin
      @(posedge clk);
      n++;
    end while (xready !== 1'b1 && n < 50);
    xreq <= '0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (xack !== 1'b1 && n < 50);
    cmp(16'(n), lat);
  endtask : xacc
  // results that appear later are compared against the oldest note
  always @(posedge clk) begin
    rd_d <= sfr.rd;
    if (rd_d && q.size() > 0) begin
      cmp(sfr_rdata, q.pop_front());
    end
    if (xack === 1'b1) begin
      if (xq.size() == 0) begin
        cmp(xrdata, 16'hxxxx);
      end else begin
        e = xq.pop_front();
        if (e[16]) begin
          cmp(xrdata, e[15:0]);
        end
      end
    end
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    sfr = '0;
    xreq = '0;
    tb_p0 = 16'h3c1f;
    tb_p1 = 16'h0000;
    tb_p2 = 16'h0000;
    mem_on = 1'b0;
    m = 2'b00;
    seed = 32'hc9d2fae1;
    repeat (10) @(posedge clk);
    cmp(16'(p0_pullup), 16'h0001);
    cmp(p0_oe, 16'h0000);
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    cmp(16'(p0_pullup), 16'h0000);
    cmp(16'(ext_bus_en), 16'h0000);
    rd(SP_STD, ADDR_BUSCFG, 16'h001f);
    rd(SP_EXT, ADDR_RCFG, 16'h003c);
    wr(SP_EXT, ADDR_RCFG, 16'hffff);
    rd(SP_EXT, ADDR_RCFG, 16'h003c);
    wr(SP_STD, ADDR_PORT2_DIR, 16'hffff);
    rd(SP_STD, ADDR_PORT2, 16'h0000);
    wr(SP_EXT, ADDR_PORT2_DRAIN, 16'hff00);
    wr(SP_STD, ADDR_PORT2, 16'hf0f0);
    repeat (3) @(posedge clk);
    cmp(p2_out, 16'h00f0);
    cmp(p2_oe, 16'h0fff);
    rd(SP_STD, ADDR_PORT2, 16'hf0f0);
    for (int i = 0; i < 4; i++) begin
      rv[i] = $random(seed);
      wr(SP_EXT, dd[i], 16'hffff);
      wr(SP_STD, da[i], rv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(SP_STD, da[i], {8'h00, rv[i][7:0]});
      rd(SP_EXT, dd[i], 16'h00ff);
    end
    repeat (3) @(posedge clk);
    cmp(p0_out, {rv[1][7:0], rv[0][7:0]});
    cmp(p1_out, {rv[3][7:0], rv[2][7:0]});
    wr(SP_EXT, ADDR_DP0H, 16'h000f);
    repeat (3) @(posedge clk);
    cmp(p0_oe, 16'h0fff);
    rd(SP_STD, ADDR_P0H, {8'h00, 4'h3, rv[1][3:0]});
    // the latches are loaded by the bus while it owns them
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(SP_STD, ADDR_BUSCFG, {8'h00, k[1:0], 6'h20});
      mem_on = 1'b1;
      repeat (3) @(posedge clk);
      cmp(16'(ext_bus_en), 16'h0001);
      a = $random(seed) & 16'hfffe;
      a1 = a + 16'h0001;
      r = {a1[7:0] ^ 8'h96, a[7:0] ^ 8'h96};
      xacc(1'b0, a, 16'h0000, r, (k[0] ? 16'd5 : 16'd4) * (k[1] ? 16'd1 : 16'd2) + 16'd1);
      if (k[1]) begin
        w = $random(seed);
        xacc(1'b1, a, w, 16'h0000, (k[0] ? 16'd6 : 16'd5));
        cmp(seen, w);
      end
      if (k == 0) begin
        cmp({8'h00, p0_oe[15:8]}, 16'h000f);
      end
      if (k[0]) begin
        cmp(p1_oe, 16'hffff);
      end
    end
    wr(SP_STD, ADDR_BUSCFG, 16'h0000);
    mem_on = 1'b0;
    repeat (3) @(posedge clk);
    cmp(16'(ext_bus_en), 16'h0000);
    cmp(p0_oe, 16'h0fff);
    wr(SP_EXT, ADDR_PORT1_HI_DIR, 16'h000f);
    for (int i = 0; i < 3; i++) begin
      tb_p1 <= $random(seed);
      repeat (14) @(posedge clk);
      cmp({12'h000, cc2_capture}, {12'h000, tb_p1[15:12]});
    end
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule : testbench
`default_nettype wire
